//--- rtl/audio_rx_pkg.sv
package audio_rx_pkg;

  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned SAMPLE_W   = 24;
  localparam int unsigned SHIFT_W    = 32;
  localparam int unsigned CNT_W      = 6;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONFIG  = 6'h01;
  localparam logic [5:0] IDX_CHAN1   = 6'h02;
  localparam logic [5:0] IDX_CHAN2   = 6'h03;
  localparam logic [5:0] IDX_STATUS  = 6'h04;

  localparam logic [7:0] CFG_RESET   = 8'h80;

  // audio_input_config fields
  localparam int unsigned FMT_LSB    = 0;
  localparam int unsigned LEN_LSB    = 2;
  localparam int unsigned ORDER_BIT  = 4;
  localparam int unsigned DELAY_BIT  = 5;
  localparam int unsigned MAP1_BIT   = 6;
  localparam int unsigned MAP2_BIT   = 7;

  // status fields
  localparam int unsigned STAT_LEN_LSB   = 0;
  localparam int unsigned STAT_LOCK_BIT  = 8;
  localparam int unsigned STAT_READY_BIT = 9;

  // justification codes, format bits 1:0
  localparam logic [1:0] FMT_I2S     = 2'h0;
  localparam logic [1:0] FMT_LEFT    = 2'h1;
  localparam logic [1:0] FMT_RIGHT   = 2'h2;

  // word length codes, format bits 3:2
  localparam logic [1:0] LEN_CODE_24 = 2'h0;
  localparam logic [1:0] LEN_CODE_20 = 2'h1;
  localparam logic [1:0] LEN_CODE_18 = 2'h2;
  localparam logic [1:0] LEN_CODE_16 = 2'h3;
  localparam logic [4:0] WLEN_24     = 5'h18;
  localparam logic [4:0] WLEN_20     = 5'h14;
  localparam logic [4:0] WLEN_18     = 5'h12;
  localparam logic [4:0] WLEN_16     = 5'h10;
  localparam logic [4:0] WLEN_15     = 5'h0f;

  // bits per half frame at 32 bit clocks per frame
  localparam logic [5:0] HALF_32FS   = 6'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

endpackage

//--- rtl/sync_two_flop.sv
module sync_two_flop #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

//--- rtl/serial_audio_input_receiver.sv
module serial_audio_input_receiver
  import audio_rx_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [DATA_W/8-1:0] wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [DATA_W-1:0]        rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                word_clock_in,
  input  wire logic                bit_clock_in,
  input  wire logic                serial_data_in,
  output logic [SAMPLE_W-1:0]      chan1_sample,
  output logic [SAMPLE_W-1:0]      chan2_sample,
  output logic                     sample_strobe
);

  logic [7:0]          cfg_q;
  wr_state_t           wr_state_q;
  logic                aw_got_q;
  logic                w_got_q;
  logic [5:0]          widx_q;
  logic [DATA_W-1:0]   wdata_q;
  logic                wstrb0_q;
  logic                wr_go;
  logic                rd_take;
  logic [5:0]          ridx;
  logic                wmapped;

  logic                lr_s;
  logic                bclk_s;
  logic                sd_s;
  logic                bclk_dly_q;
  logic                bclk_use;
  logic                bclk_prev_q;
  logic                bclk_rise;
  logic                lr_q;
  logic                lr_change;
  logic                synced_q;
  logic [CNT_W-1:0]    bit_cnt_q;
  logic [CNT_W-1:0]    cnt_next;
  logic [CNT_W-1:0]    half_len_q;
  logic [SHIFT_W-1:0]  sh_q;
  logic [SHIFT_W-1:0]  sh_next;
  logic [1:0]          fmt;
  logic [4:0]          width;
  logic                cap_fire;
  logic [SHIFT_W-1:0]  cap_raw;
  logic                cap_right;
  logic [SAMPLE_W-1:0] left_q;
  logic [SAMPLE_W-1:0] right_q;
  logic                pend_q;
  logic                ready_q;

  // register bus, write side
  assign awready = (wr_state_q == WR_IDLE) && !aw_got_q;
  assign wready  = (wr_state_q == WR_IDLE) && !w_got_q;
  assign wr_go   = (wr_state_q == WR_IDLE) && aw_got_q && w_got_q;
  assign wmapped = (widx_q == IDX_CONFIG) || (widx_q == IDX_CHAN1) ||
                   (widx_q == IDX_CHAN2)  || (widx_q == IDX_STATUS);

  // address and data may arrive in either order; both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      widx_q   <= '0;
    end else if (awvalid && awready) begin
      aw_got_q <= 1'b1;
      widx_q   <= awaddr[7:2];
    end else if (wr_go) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q  <= 1'b0;
      wdata_q  <= '0;
      wstrb0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_got_q  <= 1'b1;
      wdata_q  <= wdata;
      wstrb0_q <= wstrb[0];
    end else if (wr_go) begin
      w_got_q  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= WR_IDLE;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end else begin
      unique case (wr_state_q)
        WR_IDLE: begin
          if (wr_go) begin
            wr_state_q <= WR_RESP;
            bvalid     <= 1'b1;
            bresp      <= wmapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state_q <= WR_IDLE;
            bvalid     <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= WR_IDLE;
          bvalid     <= 1'b0;
        end
      endcase
    end
  end

  // only lane 0 carries the 8-bit config; other registers are read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RESET;
    end else if (wr_go && widx_q == IDX_CONFIG && wstrb0_q) begin
      cfg_q <= wdata_q[7:0];
    end
  end

  // register bus, read side
  assign arready = !rvalid;
  assign rd_take = arvalid && arready;
  assign ridx    = araddr[7:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rresp  <= RESP_OKAY;
      rdata  <= '0;
      unique case (ridx)
        IDX_CONFIG: rdata[7:0]             <= cfg_q;
        IDX_CHAN1:  rdata[SAMPLE_W-1:0]    <= chan1_sample;
        IDX_CHAN2:  rdata[SAMPLE_W-1:0]    <= chan2_sample;
        IDX_STATUS: begin
          rdata[STAT_LEN_LSB +: CNT_W] <= half_len_q;
          rdata[STAT_LOCK_BIT]         <= synced_q;
          rdata[STAT_READY_BIT]        <= ready_q;
        end
        default:    rresp                  <= RESP_SLVERR;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // new pair flag; a strobe in the clearing cycle wins over the read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_q <= 1'b0;
    end else if (sample_strobe) begin
      ready_q <= 1'b1;
    end else if (rd_take && ridx == IDX_CHAN2) begin
      ready_q <= 1'b0;
    end
  end

  // link front end
  // link pins come from the external master's clocks, never ours
  sync_two_flop #(
    .WIDTH (3)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({word_clock_in, bit_clock_in, serial_data_in}),
    .q       ({lr_s, bclk_s, sd_s})
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bclk_dly_q  <= 1'b0;
      bclk_prev_q <= 1'b0;
    end else begin
      bclk_dly_q  <= bclk_s;
      bclk_prev_q <= bclk_use;
    end
  end

  // the delayed clock samples data one core cycle later, for masters
  // whose data edge sits too close to the clock edge
  assign bclk_use  = cfg_q[DELAY_BIT] ? bclk_dly_q : bclk_s;
  assign bclk_rise = bclk_use && !bclk_prev_q;
  assign lr_change = bclk_rise && (lr_s != lr_q);

  // deserialiser
  assign fmt      = cfg_q[FMT_LSB +: 2];
  assign sh_next  = {sh_q[SHIFT_W-2:0], sd_s};
  assign cnt_next = lr_change ? '0 :
                    (&bit_cnt_q) ? bit_cnt_q : bit_cnt_q + 1'b1;

  always_comb begin
    unique case (cfg_q[LEN_LSB +: 2])
      LEN_CODE_24: width = WLEN_24;
      LEN_CODE_20: width = WLEN_20;
      LEN_CODE_18: width = WLEN_18;
      LEN_CODE_16: width = WLEN_16;
    endcase
    // at 32 bit clocks per frame an I2S half frame holds 15 bits
    if (fmt != FMT_LEFT && fmt != FMT_RIGHT &&
        cfg_q[LEN_LSB +: 2] == LEN_CODE_16 && half_len_q == HALF_32FS)
      width = WLEN_15;
  end

  // code 11 in bits 1:0 is undefined and falls back to I2S
  always_comb begin
    cap_fire = 1'b0;
    cap_raw  = sh_next;
    if (bclk_rise && synced_q) begin
      if (fmt == FMT_RIGHT) begin
        cap_fire = lr_change;
        cap_raw  = sh_q;
      end else if (fmt == FMT_LEFT) begin
        cap_fire = !lr_change &&
                   cnt_next == CNT_W'(width - 5'h01);
      end else begin
        cap_fire = !lr_change && cnt_next == CNT_W'(width);
      end
    end
  end

  // word clock low marks the left channel; lr_q is the half frame's level
  assign cap_right = lr_q;

  function automatic logic [SAMPLE_W-1:0] align_word(
    input logic [SHIFT_W-1:0] raw,
    input logic [4:0]         w,
    input logic               lsb_first
  );
    logic [SHIFT_W-1:0] v;
    logic [SHIFT_W-1:0] r;
    v = raw & ((SHIFT_W'(1) << w) - SHIFT_W'(1));
    r = '0;
    if (lsb_first) begin
      for (int i = 0; i < SHIFT_W; i++)
        r[i] = v[SHIFT_W-1-i];
      v = r >> (6'h20 - {1'b0, w});
    end
    align_word = v[SAMPLE_W-1:0] << (5'h18 - w);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lr_q       <= 1'b0;
      synced_q   <= 1'b0;
      bit_cnt_q  <= '0;
      half_len_q <= '0;
      sh_q       <= '0;
    end else if (bclk_rise) begin
      lr_q      <= lr_s;
      bit_cnt_q <= cnt_next;
      sh_q      <= sh_next;
      if (lr_change) begin
        synced_q   <= 1'b1;
        half_len_q <= (&bit_cnt_q) ? bit_cnt_q : bit_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_q  <= '0;
      right_q <= '0;
      pend_q  <= 1'b0;
    end else begin
      pend_q <= cap_fire && cap_right;
      if (cap_fire && !cap_right)
        left_q  <= align_word(cap_raw, width, cfg_q[ORDER_BIT]);
      if (cap_fire && cap_right)
        right_q <= align_word(cap_raw, width, cfg_q[ORDER_BIT]);
    end
  end

  // a pair leaves once the right word is in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan1_sample  <= '0;
      chan2_sample  <= '0;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= pend_q;
      if (pend_q) begin
        chan1_sample <= cfg_q[MAP1_BIT] ? right_q : left_q;
        chan2_sample <= cfg_q[MAP2_BIT] ? right_q : left_q;
      end
    end
  end

  // checks
  sequence s_right_cap;
    cap_fire && cap_right;
  endsequence

  property p_cfg_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> cfg_q == CFG_RESET;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("config not at reset value");

  property p_cfg_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && widx_q == IDX_CONFIG && wstrb0_q |=>
        cfg_q == $past(wdata_q[7:0]) && bvalid;
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write not applied");

  property p_delay;
    @(posedge aclk) disable iff (!aresetn)
      cfg_q[DELAY_BIT] |-> bclk_use == $past(bclk_s);
  endproperty
  a_delay: assert property (p_delay)
    else $error("bit clock delay wrong");

  property p_map1;
    @(posedge aclk) disable iff (!aresetn)
      s_right_cap ##1 pend_q |=> sample_strobe &&
        chan1_sample == ($past(cfg_q[MAP1_BIT]) ? $past(right_q)
                                                : $past(left_q));
  endproperty
  a_map1: assert property (p_map1)
    else $error("channel 1 mapping wrong");

  property p_map2;
    @(posedge aclk) disable iff (!aresetn)
      sample_strobe |->
        chan2_sample == ($past(cfg_q[MAP2_BIT]) ? $past(right_q)
                                                : $past(left_q));
  endproperty
  a_map2: assert property (p_map2)
    else $error("channel 2 mapping wrong");

  property p_i2s_cap;
    @(posedge aclk) disable iff (!aresetn)
      bclk_rise && synced_q && fmt == FMT_I2S && !lr_change &&
      cnt_next == CNT_W'(width) |-> cap_fire ##1 !cap_fire;
  endproperty
  a_i2s_cap: assert property (p_i2s_cap)
    else $error("i2s word not captured");

  property p_left_cap;
    @(posedge aclk) disable iff (!aresetn)
      bclk_rise && synced_q && fmt == FMT_LEFT && !lr_change &&
      bit_cnt_q == CNT_W'(width - 5'h02) |-> cap_fire;
  endproperty
  a_left_cap: assert property (p_left_cap)
    else $error("left-justified word not captured");

  property p_right_cap;
    @(posedge aclk) disable iff (!aresetn)
      lr_change && synced_q && fmt == FMT_RIGHT |->
        cap_fire ##2 (sample_strobe == $past(lr_q, 2));
  endproperty
  a_right_cap: assert property (p_right_cap)
    else $error("right-justified word not captured");

  property p_fifteen;
    @(posedge aclk) disable iff (!aresetn)
      fmt == FMT_I2S && cfg_q[LEN_LSB +: 2] == LEN_CODE_16 &&
      half_len_q == HALF_32FS |-> width == WLEN_15;
  endproperty
  a_fifteen: assert property (p_fifteen)
    else $error("15-bit i2s length not chosen");

endmodule

//--- bench/audio_source.sv
module audio_source (
  output logic word_clock,
  output logic bit_clock,
  output logic serial_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    word_clock  = 1'b1;
    bit_clock   = 1'b0;
    serial_data = 1'b0;
  end

  // idle slots toggle so a stale bit can never pass for a real one
  task automatic send_half(input logic wc, input logic [23:0] w,
                           input int h, input int len,
                           input logic [1:0] fmt, input logic lsb);
    int k;
    for (int i = 0; i < h; i++) begin
      k = (fmt == 2'h1) ? i : (fmt == 2'h2) ? i - (h - len) : i - 1;
      bit_clock  = 1'b0;
      word_clock = wc;
      if (k >= 0 && k < len)
        serial_data = lsb ? w[k] : w[len-1-k];
      else
        serial_data = ~serial_data;
      #80;
      bit_clock = 1'b1;
      #80;
    end
  endtask

  // h is 16, 24 or 32 bits per half frame; clock stands still afterwards
  task automatic send_frames(input logic [23:0] l, input logic [23:0] r,
                             input int h, input int len,
                             input logic [1:0] fmt, input logic lsb,
                             input int n);
    #7;
    repeat (n) begin
      send_half(1'b0, l, h, len, fmt, lsb);
      send_half(1'b1, r, h, len, fmt, lsb);
    end
    bit_clock   = 1'b0;
    serial_data = ~serial_data;
  endtask
endmodule

//--- bench/serial_audio_input_receiver_bench.sv
module serial_audio_input_receiver_bench;
  import audio_rx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic        wclk, bclk, sdata, sample_strobe;
  logic [23:0] chan1_sample, chan2_sample, mask, lw, rw, el, er;
  logic [7:0]  cfg;
  int          len, fail_count = 0, check_count = 0, cycles = 0;
  int          strobes = 0;
  // config, bits per half frame, word length
  // 8'h83 uses the undefined justification code, which decodes as i2s
  logic [7:0]  cfg_tab [14] = '{8'h80, 8'h84, 8'h88, 8'h9c, 8'h8c, 8'h81,
                                8'h8d, 8'h86, 8'h9e, 8'h8e, 8'h40, 8'he0,
                                8'h83, 8'h00};
  int          half_tab [14] = '{32, 32, 24, 32, 16, 32, 24, 32, 32, 16,
                                 32, 32, 32, 32};
  int          len_tab [14] = '{24, 20, 18, 16, 15, 24, 16, 20, 16, 16,
                                24, 24, 24, 24};

  always #10 aclk = ~aclk;

  // every test sends three frames, so three left/right pairs leave;
  // a right-justified test flushes the previous right word at its start
  always @(posedge aclk) begin
    if (sample_strobe === 1'b1) begin
      strobes <= strobes + 1;
    end
  end

  serial_audio_input_receiver serial_audio_input_receiver_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .word_clock_in(wclk), .bit_clock_in(bclk), .serial_data_in(sdata),
    .chan1_sample(chan1_sample), .chan2_sample(chan2_sample),
    .sample_strobe(sample_strobe));

  audio_source audio_source_inst (
    .word_clock(wclk), .bit_clock(bclk), .serial_data(sdata));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // the whole run is about 20k cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      cfg  = cfg_tab[i];
      len  = len_tab[i];
      mask = (24'h1 << len) - 24'h1;
      lw   = (24'hc35a96 ^ 24'(i)) & mask;
      rw   = (24'h3ca569 ^ 24'(i << 4)) & mask;
      el   = lw << (24 - len);
      er   = rw << (24 - len);
      // the first pass runs on the reset value of the config register
      if (i > 0) begin
        axi_write(8'h04, {24'h0, cfg}, resp);
        check(32'(resp), 32'(RESP_OKAY), "config write");
      end
      axi_read(8'h04, rd, resp);
      check(rd, {24'h0, cfg}, "config read");
      audio_source_inst.send_frames(lw, rw, half_tab[i], len, cfg[1:0],
                                    cfg[4], 3);
      repeat (20) @(posedge aclk);
      check(32'(chan1_sample), 32'(cfg[6] ? er : el), "chan1");
      check(32'(chan2_sample), 32'(cfg[7] ? er : el), "chan2");
      check(32'(strobes), 32'(3 * (i + 1)), "pairs");
      axi_read(8'h10, rd, resp);
      check(rd, 32'h300 | 32'(half_tab[i]), "status");
      axi_read(8'h0c, rd, resp);
      check(rd, 32'(cfg[7] ? er : el), "chan2 register");
      axi_read(8'h10, rd, resp);
      check(rd, 32'h100 | 32'(half_tab[i]), "status cleared");
      axi_read(8'h08, rd, resp);
      check(rd, 32'(cfg[6] ? er : el), "chan1 register");
      // per-entry coverage
      // justified placement of entries 5 to 9
      $display("test %0d done", i);
    end
    axi_write(8'hfc, 32'h0000_00ff, resp);
    check(32'(resp), 32'(RESP_SLVERR), "unmapped write resp");
    axi_read(8'hfc, rd, resp);
    check(32'(resp), 32'(RESP_SLVERR), "unmapped read resp");
    check(rd, 32'h0, "unmapped read data");
    axi_write(8'h08, 32'h0000_00ff, resp);
    check(32'(resp), 32'(RESP_OKAY), "read-only write resp");
    axi_read(8'h04, rd, resp);
    check(rd, 32'h0, "config kept");
    $display("test registers done");
    report_and_stop();
  end
endmodule
